// ===== tb/switching_clock_manager_chk.sv
`timescale 1ns/10ps
module switching_clock_manager_chk (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic sync_oe, // pin drive enable
  input wire logic sw_clk, // switching clock
  input wire logic [3:0] hf_trim_applied, // trim in use
  input wire logic pll_enable, // pll running
  input wire logic pll_source_ext, // external clock in use
  input wire logic spread_active // modulation running
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [2:0] since_rst;
  logic [7:0] gap;
  logic [3:0] prev_trim;
  logic [4:0] mhz;
  logic moved;
  logic mapped;

  // --------------------------------------------------------
  // helpers
  // --------------------------------------------------------
  assign mhz = (hf_trim_applied <= 4'h4) ? 5'h14 + hf_trim_applied
                                         : 5'h07 + hf_trim_applied;
  // fuse load after reset is a jump, not a step: skip it
  assign moved = (since_rst == 3'h7) && (hf_trim_applied != prev_trim);
  assign mapped = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rst <= 3'h0;
    end else if (since_rst != 3'h7) begin
      since_rst <= since_rst + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_trim <= 4'h0;
      gap <= 8'h00;
    end else begin
      prev_trim <= hf_trim_applied;
      if (hf_trim_applied != prev_trim) begin
        gap <= 8'h00;
      end else if (gap != 8'hff) begin
        gap <= gap + 8'h01;
      end
    end
  end

  sequence sw_half;
    ##[1:3] $fell(sw_clk);
  endsequence

  // --------------------------------------------------------
  // assertions
  // --------------------------------------------------------
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  chk_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  chk_trim_used: assert property (hf_trim_applied <= 4'h4 ||
    (hf_trim_applied >= 4'h9 && hf_trim_applied <= 4'hc))
    else $error("unused trim code applied");
  chk_one_step: assert property (moved |->
    (mhz - $past(mhz) == 5'h01) || ($past(mhz) - mhz == 5'h01))
    else $error("trim moved more than one step");
  chk_step_dwell: assert property (moved |-> gap >= 8'h33)
    else $error("trim step dwell too short");
  chk_trim_frozen: assert property (
    ($past(spread_active) && spread_active) ||
    ($past(pll_source_ext) && pll_source_ext) |-> $stable(hf_trim_applied))
    else $error("trim moved while frozen");
  chk_sync_spread: assert property (pll_enable |-> !spread_active)
    else $error("spreading in sync mode");
  chk_internal_only: assert property (
    !pll_enable |-> !pll_source_ext)
    else $error("external source without pll");
  chk_pin_output: assert property (sync_oe |-> !pll_enable)
    else $error("pin driven in sync mode");
  chk_sw_toggle: assert property (
    !pll_enable && $rose(sw_clk) |-> sw_half)
    else $error("switching clock half period wrong");
endmodule

bind switching_clock_manager switching_clock_manager_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sync_oe(sync_oe), .sw_clk(sw_clk), .hf_trim_applied(hf_trim_applied),
  .pll_enable(pll_enable), .pll_source_ext(pll_source_ext),
  .spread_active(spread_active)
);

// ===== tb/sync_src.sv
`timescale 1ns/10ps
module sync_src (
  input wire logic pclk, // system clock
  input wire logic [7:0] period, // cycles per period, 0 = idle
  output logic level // source drive level
);
  logic [7:0] ph;

  initial begin
    level = 1'b0;
    ph = 8'h00;
  end

  // idle means held low, so no stray edge reaches the pin before clocking
  always @(posedge pclk) begin
    if (period == 8'h00) begin
      level <= 1'b0;
      ph <= 8'h00;
    end else begin
      ph <= (ph + 8'h01 >= period) ? 8'h00 : ph + 8'h01;
      level <= (ph < period / 2);
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [8:0] fuse;
  logic sync_out;
  logic sync_oe;
  logic sw_clk;
  logic [3:0] hf_trim_applied;
  logic pll_enable;
  logic pll_source_ext;
  logic spread_active;
  logic irq_out_n;
  logic src_level;
  logic [7:0] period;
  wire logic pin;
  logic [31:0] q;
  logic e;
  int err_count;
  int cmp_count;
  int cyc;
  int s;
  int o;

  assign pin = sync_oe ? sync_out : src_level;

  switching_clock_manager dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .otp_sync_mode(fuse[8]),
    .otp_hf_trim_default(fuse[7:4]), .otp_spread_enable_default(fuse[3]),
    .otp_spread_wide_default(fuse[2]),
    .otp_ext_clock_band_default(fuse[1]),
    .otp_clock_out_default(fuse[0]), .sync_in(pin), .sync_out(sync_out),
    .sync_oe(sync_oe), .sw_clk(sw_clk), .hf_trim_applied(hf_trim_applied),
    .pll_enable(pll_enable), .pll_source_ext(pll_source_ext),
    .spread_active(spread_active), .irq_out_n(irq_out_n)
  );
  sync_src src_u (.pclk(pclk), .period(period), .level(src_level));

  // --------------------------------------------------------
  // tasks
  // --------------------------------------------------------
  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, ex, got);
    end
  endtask

  // edge counts of an accumulator clock may be off by two either way
  task automatic near(input string nm, input int ex, input int got);
    cmp_count++;
    if (got > ex + 2 || got < ex - 2) begin
      err_count++;
      $display("MISMATCH %s exp %0d got %0d", nm, ex, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    cmp(nm, ex, q & m);
  endtask

  // sw_clk and pin rising edges over 640 us
  task automatic count_edges();
    logic ps;
    logic po;
    s = 0;
    o = 0;
    ps = sw_clk;
    po = sync_out;
    repeat (6400) begin
      @(posedge pclk);
      if (sw_clk && !ps) s++;
      if (sync_out && !po) o++;
      ps = sw_clk;
      po = sync_out;
    end
  endtask

  task automatic reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  // --------------------------------------------------------
  // clock, timeout, sequence
  // --------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fuse = 9'h095;
    period = 8'h00;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    reset_dut();
    rd(clk_mgr_pkg::CTRL_ADDR, 32'hff, 32'ha9, "ctrl");
    rd(clk_mgr_pkg::MASK_ADDR, 32'hffffffff, 32'h0, "mask");
    rd(clk_mgr_pkg::STATUS_ADDR, 32'h1ef, 32'h009, "status");
    apb(1'b0, 12'h010, 32'h0);
    cmp("unmapped err", 32'h1, e);
    cmp("unmapped data", 32'h0, q);
    apb(1'b1, clk_mgr_pkg::STATUS_ADDR, 32'hffffffff);
    rd(clk_mgr_pkg::STATUS_ADDR, 32'hf, 32'h9, "status ro");
    cmp("pin oe", 32'h1, sync_oe);
    count_edges();
    near("sw 16", 1280, s);
    near("pin 16", 1280, o);
    apb(1'b1, clk_mgr_pkg::CTRL_ADDR, 32'h84);
    repeat (500) @(posedge pclk);
    cmp("trim walk", 32'h4, hf_trim_applied);
    rd(clk_mgr_pkg::FLAGS_ADDR, 32'h1, 32'h1, "freq flag");
    cmp("irq set", 32'h0, irq_out_n);
    count_edges();
    near("sw 24", 1920, s);
    near("pin 24", 1920, o);
    apb(1'b1, clk_mgr_pkg::MASK_ADDR, 32'h1);
    repeat (3) @(posedge pclk);
    cmp("irq masked", 32'h1, irq_out_n);
    apb(1'b1, clk_mgr_pkg::MASK_ADDR, 32'h0);
    apb(1'b1, clk_mgr_pkg::FLAGS_ADDR, 32'h1);
    repeat (3) @(posedge pclk);
    cmp("irq cleared", 32'h1, irq_out_n);
    for (int c = 5; c < 16; c++) begin
      if (c < 9 || c > 12) apb(1'b1, clk_mgr_pkg::CTRL_ADDR, c);
    end
    repeat (60) @(posedge pclk);
    cmp("unused kept", 32'h4, hf_trim_applied);
    rd(clk_mgr_pkg::CTRL_ADDR, 32'hff, 32'h04, "ctrl unused");
    count_edges();
    cmp("pin off", 32'h0, o);
    apb(1'b1, clk_mgr_pkg::CTRL_ADDR, 32'h10);
    repeat (200) @(posedge pclk);
    cmp("spread on", 32'h1, spread_active);
    cmp("trim frozen", 32'h4, hf_trim_applied);
    apb(1'b1, clk_mgr_pkg::CTRL_ADDR, 32'h00);
    repeat (300) @(posedge pclk);
    cmp("spread off", 32'h0, spread_active);
    cmp("trim resumed", 32'h0, hf_trim_applied);
    fuse <= 9'h108;
    period <= 8'h04;
    reset_dut();
    cmp("pll on", 32'h1, pll_enable);
    cmp("no spread", 32'h0, spread_active);
    cmp("pin input", 32'h0, sync_oe);
    repeat (300) @(posedge pclk);
    cmp("ext used", 32'h1, pll_source_ext);
    rd(clk_mgr_pkg::STATUS_ADDR, 32'h30, 32'h20, "status ext");
    apb(1'b1, clk_mgr_pkg::CTRL_ADDR, 32'h02);
    repeat (200) @(posedge pclk);
    cmp("trim sync", 32'h0, hf_trim_applied);
    apb(1'b1, clk_mgr_pkg::CTRL_ADDR, 32'h00);
    period <= 8'h00;
    repeat (300) @(posedge pclk);
    cmp("fallback", 32'h0, pll_source_ext);
    rd(clk_mgr_pkg::FLAGS_ADDR, 32'h2, 32'h2, "fault flag");
    cmp("irq fault", 32'h0, irq_out_n);
    rd(clk_mgr_pkg::STATUS_ADDR, 32'h10, 32'h10, "live bad");
    period <= 8'h04;
    repeat (300) @(posedge pclk);
    rd(clk_mgr_pkg::STATUS_ADDR, 32'h30, 32'h0, "live ok");
    apb(1'b1, clk_mgr_pkg::FLAGS_ADDR, 32'h3);
    repeat (300) @(posedge pclk);
    cmp("ext back", 32'h1, pll_source_ext);
    period <= 8'h08;
    repeat (300) @(posedge pclk);
    cmp("out of band", 32'h0, pll_source_ext);
    apb(1'b1, clk_mgr_pkg::CTRL_ADDR, 32'h40);
    period <= 8'h19;
    apb(1'b1, clk_mgr_pkg::FLAGS_ADDR, 32'h3);
    repeat (400) @(posedge pclk);
    cmp("low band", 32'h1, pll_source_ext);
    end_sim();
  end
endmodule

// ===== verilog/clk_mgr_pkg.sv
package clk_mgr_pkg;

  // ------------------------------------------------------------
  // clocking and timing
  // ------------------------------------------------------------
  localparam int PCLK_KHZ = 10000;
  localparam int PCLK_NS = 100;
  localparam int LP_CLK_KHZ = 100;
  localparam int LP_DIV = PCLK_KHZ / LP_CLK_KHZ;
  localparam int STEP_DWELL_NS = 5200;
  localparam int STEP_CYCLES = (STEP_DWELL_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int SS_MOD_HZ = 24000;

  // ------------------------------------------------------------
  // switching clock synthesis: 16 units per MHz, divide by 8
  // ------------------------------------------------------------
  localparam int HF_DIV = 8;
  localparam int NCO_UNITS = 16;
  localparam int NCO_HALF = PCLK_KHZ / 1000 * HF_DIV * NCO_UNITS / 2;
  localparam int NOMINAL_MHZ = 20;
  localparam int SS_NARROW_PCT = 5;
  localparam int SS_WIDE_PCT = 10;
  localparam int SS_DEV_NARROW = NOMINAL_MHZ * NCO_UNITS * SS_NARROW_PCT / 100;
  localparam int SS_DEV_WIDE = NOMINAL_MHZ * NCO_UNITS * SS_WIDE_PCT / 100;
  localparam int SS_STEP_NARROW =
    PCLK_KHZ * 1000 / (SS_MOD_HZ * 4 * SS_DEV_NARROW);
  localparam int SS_STEP_WIDE =
    PCLK_KHZ * 1000 / (SS_MOD_HZ * 4 * SS_DEV_WIDE);

  // ------------------------------------------------------------
  // external clock bands, as periods in pclk cycles
  // ------------------------------------------------------------
  localparam int EXT_HI_MIN_KHZ = 2000;
  localparam int EXT_HI_MAX_KHZ = 3000;
  localparam int EXT_LO_MIN_KHZ = 333;
  localparam int EXT_LO_MAX_KHZ = 500;
  localparam int EXT_HI_PMIN = PCLK_KHZ / EXT_HI_MAX_KHZ;
  localparam int EXT_HI_PMAX = PCLK_KHZ / EXT_HI_MIN_KHZ;
  localparam int EXT_LO_PMIN = PCLK_KHZ / EXT_LO_MAX_KHZ;
  localparam int EXT_LO_PMAX = PCLK_KHZ / EXT_LO_MIN_KHZ;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] FLAGS_ADDR = 12'h008;
  localparam logic [11:0] MASK_ADDR = 12'h00c;
  localparam int CTRL_TRIM_LSB = 0;
  localparam int CTRL_SPREAD_EN = 4;
  localparam int CTRL_SPREAD_WIDE = 5;
  localparam int CTRL_LOW_BAND = 6;
  localparam int CTRL_CLK_OUT_EN = 7;
  localparam int ST_FAULT_LIVE = 4;
  localparam int ST_USING_EXT = 5;
  localparam int ST_SPREAD_ACT = 6;
  localparam int ST_STEPPING = 7;
  localparam int ST_PLL_EN = 8;
  localparam int FLAG_FREQ = 0;
  localparam int FLAG_FAULT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // ------------------------------------------------------------
  // trim code mapping
  // ------------------------------------------------------------
  function automatic logic code_used(input logic [3:0] code);
    return (code <= 4'h4) || (code >= 4'h9 && code <= 4'hc);
  endfunction

  function automatic logic [4:0] code_to_mhz(input logic [3:0] code);
    if (code <= 4'h4) begin
      return 5'h14 + {1'b0, code};
    end
    return 5'h07 + {1'b0, code};
  endfunction

  function automatic logic [3:0] mhz_to_code(input logic [4:0] mhz);
    if (mhz >= 5'h14) begin
      return 4'(mhz - 5'h14);
    end
    return 4'(mhz - 5'h07);
  endfunction

endpackage

// ===== verilog/ext_clock_monitor.sv
`timescale 1ns/10ps
module ext_clock_monitor (
  input wire logic pclk,      // system clock
  input wire logic presetn,   // async reset, active low
  ext_mon_if.mon mon          // pin in, band in, validity out
);
  logic sync1;
  logic sync2;
  logic prev;
  logic [5:0] period;
  logic [5:0] pmin;
  logic [5:0] pmax;

  assign pmin = mon.low_band ? 6'(clk_mgr_pkg::EXT_LO_PMIN)
                             : 6'(clk_mgr_pkg::EXT_HI_PMIN);
  assign pmax = mon.low_band ? 6'(clk_mgr_pkg::EXT_LO_PMAX)
                             : 6'(clk_mgr_pkg::EXT_HI_PMAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync1 <= mon.pin_level;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign mon.level = prev;

  // ------------------------------------------------------------
  // period between rising edges must sit inside the band
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period <= 6'h00;
      mon.valid <= 1'b0;
    end else if (sync2 && !prev) begin
      mon.valid <= (period + 6'h01 >= pmin) && (period + 6'h01 <= pmax);
      period <= 6'h00;
    end else if (period > pmax) begin
      mon.valid <= 1'b0;
    end else begin
      period <= period + 6'h01;
    end
  end
endmodule

// ===== verilog/ext_mon_if.sv
`timescale 1ns/10ps
interface ext_mon_if;
  logic pin_level;
  logic low_band;
  logic valid;
  logic level;

  modport mon (input pin_level, input low_band, output valid, output level);
  modport top (output pin_level, output low_band, input valid, input level);
endinterface

// ===== verilog/switching_clock_manager.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module switching_clock_manager (
  input wire logic pclk,                      // 10 MHz system clock
  input wire logic presetn,                   // async reset, active low
  input wire logic psel,                      // apb select
  input wire logic penable,                   // apb access phase
  input wire logic pwrite,                    // apb write
  input wire logic [11:0] paddr,              // apb byte address
  input wire logic [31:0] pwdata,             // apb write data
  output logic [31:0] prdata,                 // apb read data
  output logic pready,                        // apb ready
  output logic pslverr,                       // apb error, unmapped
  input wire logic otp_sync_mode,             // fuse: external sync mode
  input wire logic [3:0] otp_hf_trim_default, // fuse: trim default
  input wire logic otp_spread_enable_default, // fuse: spread default
  input wire logic otp_spread_wide_default,   // fuse: spread range
  input wire logic otp_ext_clock_band_default, // fuse: input band
  input wire logic otp_clock_out_default,     // fuse: clock out
  input wire logic sync_in,                   // sync pin input level
  output logic sync_out,                      // sync pin output level
  output logic sync_oe,                       // sync pin output enable
  output logic sw_clk,                        // switching clock
  output logic [3:0] hf_trim_applied,         // trim code in use
  output logic pll_enable,                    // pll running
  output logic pll_source_ext,                // pll fed from sync pin
  output logic spread_active,                 // modulation running
  output logic irq_out_n                      // interrupt, active low
);

  // ------------------------------------------------------------
  // fuse capture after reset release
  // ------------------------------------------------------------
  logic [8:0] otp_s1;
  logic [8:0] otp_s2;
  logic [1:0] load_cnt;
  logic loaded;
  logic sync_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_s1 <= 9'h000;
      otp_s2 <= 9'h000;
      load_cnt <= 2'h0;
    end else begin
      otp_s1 <= {otp_sync_mode, otp_hf_trim_default,
                 otp_spread_enable_default, otp_spread_wide_default,
                 otp_ext_clock_band_default, otp_clock_out_default};
      otp_s2 <= otp_s1;
      if (load_cnt != 2'h3) begin
        load_cnt <= load_cnt + 2'h1;
      end
    end
  end

  assign loaded = (load_cnt == 2'h3);

  // ------------------------------------------------------------
  // 100 kHz control tick
  // ------------------------------------------------------------
  logic [6:0] lp_cnt;
  logic lp_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_cnt <= 7'h00;
      lp_tick <= 1'b0;
    end else begin
      lp_tick <= (lp_cnt == 7'(clk_mgr_pkg::LP_DIV - 1));
      if (lp_cnt == 7'(clk_mgr_pkg::LP_DIV - 1)) begin
        lp_cnt <= 7'h00;
      end else begin
        lp_cnt <= lp_cnt + 7'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave and registers
  // ------------------------------------------------------------
  logic [7:0] ctrl;
  logic [1:0] flags;
  logic [1:0] mask;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [8:0] status;
  logic wr_en;
  logic fault_live;
  logic using_ext;
  logic stepping;
  logic [4:0] applied_mhz;
  logic [4:0] target_mhz;
  logic [3:0] wr_trim;

  assign wr_en = psel && penable && pready && pwrite;
  assign wr_trim = pwdata[clk_mgr_pkg::CTRL_TRIM_LSB +: 4];
  assign status = {pll_enable, stepping, spread_active, using_ext,
                   fault_live, hf_trim_applied};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      // answer is prepared in setup so the access phase takes one cycle
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      unique case (paddr)
        clk_mgr_pkg::CTRL_ADDR: prdata <= {24'h000000, ctrl};
        clk_mgr_pkg::STATUS_ADDR: prdata <= {23'h000000, status};
        clk_mgr_pkg::FLAGS_ADDR: prdata <= {30'h00000000, flags};
        clk_mgr_pkg::MASK_ADDR: prdata <= {30'h00000000, mask};
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= clk_mgr_pkg::CTRL_RESET;
      sync_mode <= 1'b0;
    end else if (load_cnt == 2'h2) begin
      sync_mode <= otp_s2[8];
      ctrl <= {otp_s2[0], otp_s2[1], otp_s2[2], otp_s2[3],
               otp_s2[7:4]};
    end else if (wr_en && paddr == clk_mgr_pkg::CTRL_ADDR) begin
      ctrl[7:4] <= pwdata[7:4];
      if (clk_mgr_pkg::code_used(wr_trim)) begin
        ctrl[clk_mgr_pkg::CTRL_TRIM_LSB +: 4] <= wr_trim;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= clk_mgr_pkg::MASK_RESET;
    end else if (wr_en && paddr == clk_mgr_pkg::MASK_ADDR) begin
      mask <= pwdata[1:0];
    end
  end

  // write one to clear; a new event in the same cycle wins
  assign flag_clr = (wr_en && paddr == clk_mgr_pkg::FLAGS_ADDR)
                    ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 2'h0;
      irq_out_n <= 1'b1;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
      irq_out_n <= ~|(flags & ~mask);
    end
  end

  // ------------------------------------------------------------
  // external clock supervision
  // ------------------------------------------------------------
  ext_mon_if mon_bus ();
  logic ext_valid_q;

  assign mon_bus.pin_level = sync_in;
  assign mon_bus.low_band = ctrl[clk_mgr_pkg::CTRL_LOW_BAND];

  ext_clock_monitor u_monitor (
    .pclk(pclk),
    .presetn(presetn),
    .mon(mon_bus.mon)
  );

  // decisions are taken on the slow tick, like every debounce here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_live <= 1'b0;
      using_ext <= 1'b0;
      ext_valid_q <= 1'b0;
    end else if (lp_tick && loaded && sync_mode) begin
      ext_valid_q <= mon_bus.valid;
      fault_live <= !mon_bus.valid;
      if (!mon_bus.valid) begin
        using_ext <= 1'b0;
      end else if (!flags[clk_mgr_pkg::FLAG_FAULT]) begin
        using_ext <= 1'b1;
      end
    end else if (!sync_mode) begin
      fault_live <= 1'b0;
      using_ext <= 1'b0;
      ext_valid_q <= 1'b0;
    end
  end

  // a grounded pin never raises a fault: only the loss of a clock
  // that was in use does
  assign flag_set[clk_mgr_pkg::FLAG_FAULT] =
    lp_tick && loaded && sync_mode && using_ext && !mon_bus.valid;

  // ------------------------------------------------------------
  // trim stepping
  // ------------------------------------------------------------
  logic [5:0] dwell;
  logic hold;
  assign target_mhz =
    clk_mgr_pkg::code_to_mhz(ctrl[clk_mgr_pkg::CTRL_TRIM_LSB +: 4]);
  // spread bit read directly: no step slips in before spread_active rises
  assign hold = using_ext ||
                (!sync_mode && ctrl[clk_mgr_pkg::CTRL_SPREAD_EN]);
  assign stepping = applied_mhz != target_mhz;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_mhz <= 5'(clk_mgr_pkg::NOMINAL_MHZ);
      dwell <= 6'h00;
    end else if (load_cnt == 2'h2) begin
      applied_mhz <= clk_mgr_pkg::code_to_mhz(otp_s2[7:4]);
      dwell <= 6'h00;
    end else if (!hold && stepping) begin
      if (dwell == 6'h00) begin
        dwell <= 6'(clk_mgr_pkg::STEP_CYCLES - 1);
        if (target_mhz > applied_mhz) begin
          applied_mhz <= applied_mhz + 5'h01;
        end else begin
          applied_mhz <= applied_mhz - 5'h01;
        end
      end else begin
        dwell <= dwell - 6'h01;
      end
    end else if (dwell != 6'h00) begin
      dwell <= dwell - 6'h01;
    end
  end

  assign flag_set[clk_mgr_pkg::FLAG_FREQ] =
    loaded && !hold && stepping && dwell == 6'h00 &&
    (target_mhz == applied_mhz + 5'h01 ||
     target_mhz + 5'h01 == applied_mhz);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_trim_applied <= 4'h0;
      pll_enable <= 1'b0;
      pll_source_ext <= 1'b0;
      spread_active <= 1'b0;
    end else begin
      hf_trim_applied <= clk_mgr_pkg::mhz_to_code(applied_mhz);
      pll_enable <= sync_mode;
      pll_source_ext <= using_ext;
      spread_active <= loaded && !sync_mode &&
                       ctrl[clk_mgr_pkg::CTRL_SPREAD_EN];
    end
  end

  // ------------------------------------------------------------
  // spread-spectrum triangle around the nominal frequency
  // ------------------------------------------------------------
  logic signed [6:0] tri_ofs;
  logic tri_up;
  logic [3:0] ss_cnt;
  logic [3:0] ss_period;
  logic signed [6:0] ss_dev;

  assign ss_period = ctrl[clk_mgr_pkg::CTRL_SPREAD_WIDE]
                     ? 4'(clk_mgr_pkg::SS_STEP_WIDE)
                     : 4'(clk_mgr_pkg::SS_STEP_NARROW);
  assign ss_dev = ctrl[clk_mgr_pkg::CTRL_SPREAD_WIDE]
                  ? 7'(clk_mgr_pkg::SS_DEV_WIDE)
                  : 7'(clk_mgr_pkg::SS_DEV_NARROW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tri_ofs <= 7'sh00;
      tri_up <= 1'b1;
      ss_cnt <= 4'h0;
    end else if (!spread_active) begin
      tri_ofs <= 7'sh00;
      tri_up <= 1'b1;
      ss_cnt <= 4'h0;
    end else if (ss_cnt >= ss_period - 4'h1) begin
      ss_cnt <= 4'h0;
      if (tri_up && tri_ofs >= ss_dev) begin
        tri_up <= 1'b0;
        tri_ofs <= tri_ofs - 7'sh01;
      end else if (!tri_up && tri_ofs <= -ss_dev) begin
        tri_up <= 1'b1;
        tri_ofs <= tri_ofs + 7'sh01;
      end else if (tri_up) begin
        tri_ofs <= tri_ofs + 7'sh01;
      end else begin
        tri_ofs <= tri_ofs - 7'sh01;
      end
    end else begin
      ss_cnt <= ss_cnt + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // switching clock: phase accumulator equal to high clock / 8
  // ------------------------------------------------------------
  logic [10:0] nco_acc;
  logic [10:0] nco_sum;
  logic [9:0] nco_inc;
  logic int_clk;

  // the 16..24 MHz clock is not built here; its rate sets the step
  always_comb begin
    if (spread_active) begin
      nco_inc = 10'(clk_mgr_pkg::NOMINAL_MHZ * clk_mgr_pkg::NCO_UNITS)
                + 10'(tri_ofs);
    end else begin
      nco_inc = 10'({applied_mhz, 4'h0});
    end
  end

  assign nco_sum = nco_acc + {1'b0, nco_inc};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_acc <= 11'h000;
      int_clk <= 1'b0;
    end else if (nco_sum >= 11'(clk_mgr_pkg::NCO_HALF)) begin
      nco_acc <= nco_sum - 11'(clk_mgr_pkg::NCO_HALF);
      int_clk <= !int_clk;
    end else begin
      nco_acc <= nco_sum;
    end
  end

  // ------------------------------------------------------------
  // clock selection and sync pin drive
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_clk <= 1'b0;
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
    end else begin
      sw_clk <= using_ext ? mon_bus.level : int_clk;
      sync_oe <= loaded && !sync_mode && otp_s2[0];
      sync_out <= ctrl[clk_mgr_pkg::CTRL_CLK_OUT_EN] && int_clk;
    end
  end

endmodule
